// ---- inc/wdsc_pkg.sv ----
// Package for the watchdog with stop and configuration logic.
// Assumes a 32-bit AHB-Lite bus with one word per register index.
package wdsc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONFIG_TWO   = 16'h001E;
  localparam logic [15:0] IDX_CONFIG_ONE   = 16'h001F;
  localparam logic [15:0] IDX_RESET_CAUSE  = 16'h0020;
  localparam logic [15:0] IDX_SERVICE      = 16'hFFFF;

  // Field positions in system_config_one
  localparam int BIT_WD_DISABLE  = 0;
  localparam int BIT_STOP_ENABLE = 1;
  localparam int BIT_SHORT_REC   = 3;
  localparam int BIT_RATE_SELECT = 7;
  // Field position in system_config_two
  localparam int BIT_RST_PIN_EN  = 0;
  // Field positions in reset cause register
  localparam int BIT_CAUSE_WD    = 0;
  localparam int BIT_STAT_STOP   = 1;
  localparam int BIT_STAT_WDCNT  = 8;

  // Reset values
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;

  // Counter widths and cycle counts of the oscillator clock
  localparam int PRESC_BITS        = 12;
  localparam int WD_BITS           = 6;
  localparam int CNT_BITS          = PRESC_BITS + WD_BITS;
  localparam int SERVICE_LOW_STAGE = 4;
  localparam int RST_PULSE_CYCLES  = 32;
  localparam int POR_CLEAR_CYCLES  = 4096;
  localparam int REC_SHORT_CYCLES  = 32;
  localparam int REC_LONG_CYCLES   = 4096;

  // Decoded configuration bits
  typedef struct packed {
    logic rate_select;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wdsc_cfg_t;

  // Stop handling states, Gray coded along the path
  typedef enum logic [1:0] {
    WDSC_RUN     = 2'b00,
    WDSC_STOPPED = 2'b01,
    WDSC_RECOVER = 2'b11
  } wdsc_state_t;

endpackage : wdsc_pkg

// ---- hdl/wdsc_top.sv ----
// Watchdog, prescaler, stop control and write-once configuration.
// Assumes hclk is the oscillator clock, hresetn is power-on reset and
// CPU-side strobes are synchronous to hclk.
//
// Decided for this implementation: the AHB-Lite interface to the registers.

// Notes on behaviour
// - 6-bit watchdog counter advances on carry of 12-bit prescaler.
// - Unserviced counter expires and requests reset after chosen timeout.
// - Rate select set gives 8176 cycles, clear gives 262,128.
// - Any write to service location clears watchdog and prescaler bits 11:4.
// - Reading service location returns low byte of reset vector.
// - Expiry drives reset pin low 32 cycles if enabled; sets cause flag.
// - Stop instruction clears the prescaler.
// - Prescaler is cleared once 4096 cycles after power-up.
// - Internal reset clears prescaler and watchdog counter.
// - Watchdog disable bit 1 disables, 0 enables.
// - No interrupt request; expiry only causes reset.
// - Monitor mode with test high voltage disables watchdog.
// - Watchdog keeps counting in wait mode.
// - Stop mode gates watchdog clock and clears prescaler.
// - Break in monitor mode with break disable set stops watchdog.
// - Short recovery bit: 32 cycles when 1, 4096 when 0.
// - Stop exit by low-voltage reset always uses long recovery.
// - Stop enable 1 permits stop; 0 makes stop an illegal opcode.
// - Configuration register accepts one write per reset, readable always.
module wdsc_top #(
  parameter int LONG_TIMEOUT  = 262128,
  parameter int SHORT_TIMEOUT = 8176
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // System side
  input  wire logic [7:0]  reset_vector_low,
  input  wire logic        internal_reset,
  input  wire logic        stop_request,
  input  wire logic        stop_wakeup,
  input  wire logic        lvd_reset,
  input  wire logic        monitor_mode,
  input  wire logic        test_high_voltage,
  input  wire logic        break_active,
  input  wire logic        break_watchdog_disable,
  output logic             stop_illegal,
  output logic             stop_mode,
  output logic             watchdog_reset,
  output logic             reset_pin_out,
  output logic             reset_pin_oe
);

  localparam int CB = wdsc_pkg::CNT_BITS;
  localparam int PB = wdsc_pkg::PRESC_BITS;
  localparam int LS = wdsc_pkg::SERVICE_LOW_STAGE;

  // Elaboration check of timeouts
  if (LONG_TIMEOUT < 2 || LONG_TIMEOUT > (1 << CB) ||
      SHORT_TIMEOUT < 2 || SHORT_TIMEOUT > LONG_TIMEOUT)
  begin : g_bad_timeout
    $error("wdsc_top: timeout parameters out of range");
  end

  localparam logic [CB-1:0] LONG_LAST  = CB'(LONG_TIMEOUT - 1);
  localparam logic [CB-1:0] SHORT_LAST = CB'(SHORT_TIMEOUT - 1);

  // Registers
  logic [7:0]              config_one;
  logic [7:0]              config_two;
  logic                    config_one_locked;
  logic                    config_two_locked;
  logic                    cause_watchdog;
  logic [PB-1:0]           prescaler;
  logic [wdsc_pkg::WD_BITS-1:0] wd_count;
  logic [12:0]             por_count;
  logic                    por_done;
  logic [5:0]              pulse_count;
  logic [12:0]             rec_count;
  logic                    vtst_meta;
  logic                    vtst_sync;
  logic                    wake_meta;
  logic                    wake_sync;
  wdsc_pkg::wdsc_state_t   state;

  // Bus pipeline
  logic                    dp_write;
  logic [15:0]             dp_index;
  logic                    dp_valid;

  // Combinational terms
  wdsc_pkg::wdsc_cfg_t     cfg;
  logic                    addr_ok;
  logic                    access;
  logic                    wr_service;
  logic                    wr_config_one;
  logic                    wr_config_two;
  logic                    wr_cause;
  logic                    wd_disabled;
  logic                    wd_expire;
  logic                    sys_reset;
  logic                    stop_go;
  logic [CB-1:0]           total;
  logic [31:0]             next_rdata;

  assign cfg.watchdog_disable    = config_one[wdsc_pkg::BIT_WD_DISABLE];
  assign cfg.stop_enable         = config_one[wdsc_pkg::BIT_STOP_ENABLE];
  assign cfg.short_stop_recovery = config_one[wdsc_pkg::BIT_SHORT_REC];
  assign cfg.rate_select         = config_one[wdsc_pkg::BIT_RATE_SELECT];

  // Address decode and data-phase write strobes
  assign addr_ok       = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
  assign access        = hsel && htrans[1] && hready;
  assign wr_service    = dp_valid && dp_write && (dp_index == wdsc_pkg::IDX_SERVICE);
  assign wr_config_one = dp_valid && dp_write && (dp_index == wdsc_pkg::IDX_CONFIG_ONE);
  assign wr_config_two = dp_valid && dp_write && (dp_index == wdsc_pkg::IDX_CONFIG_TWO);
  assign wr_cause      = dp_valid && dp_write && (dp_index == wdsc_pkg::IDX_RESET_CAUSE);

  // Watchdog enable and expiry; compare at or above limit, prescaler runs while disabled
  assign wd_disabled = cfg.watchdog_disable
                     || (monitor_mode && vtst_sync)
                     || (monitor_mode && break_active && break_watchdog_disable);
  assign total     = {wd_count, prescaler};
  assign wd_expire = !wd_disabled && (state == wdsc_pkg::WDSC_RUN) && (pulse_count == 6'd0)
                   && (total >= (cfg.rate_select ? SHORT_LAST : LONG_LAST));
  assign sys_reset = internal_reset || wd_expire;
  assign stop_go   = stop_request && (state == wdsc_pkg::WDSC_RUN) && cfg.stop_enable;

  // Synchronisers for pin-level inputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vtst_meta <= 1'b0;
      vtst_sync <= 1'b0;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end
    else
    begin
      vtst_meta <= test_high_voltage;
      vtst_sync <= vtst_meta;
      wake_meta <= stop_wakeup;
      wake_sync <= wake_meta;
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_index <= 16'h0000;
    end
    else
    begin
      dp_valid <= access && addr_ok;
      dp_write <= hwrite;
      dp_index <= haddr[17:2];
    end
  end

  // Read data selected in the address phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr[17:2])
      wdsc_pkg::IDX_SERVICE:     next_rdata[7:0] = reset_vector_low;
      wdsc_pkg::IDX_CONFIG_ONE:  next_rdata[7:0] = config_one;
      wdsc_pkg::IDX_CONFIG_TWO:  next_rdata[7:0] = config_two;
      wdsc_pkg::IDX_RESET_CAUSE:
      begin
        next_rdata[wdsc_pkg::BIT_CAUSE_WD]  = cause_watchdog;
        next_rdata[wdsc_pkg::BIT_STAT_STOP] = (state != wdsc_pkg::WDSC_RUN);
        next_rdata[wdsc_pkg::BIT_STAT_WDCNT +: wdsc_pkg::WD_BITS] = wd_count;
      end
      default:                   next_rdata = 32'h0000_0000;
    endcase
    if (!addr_ok)
      next_rdata = 32'h0000_0000;
  end

  // Bus answer: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (access && !hwrite)
        hrdata <= next_rdata;
    end
  end

  // First configuration register: one write per reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_one        <= wdsc_pkg::CONFIG_ONE_RESET;
      config_one_locked <= 1'b0;
    end
    else if (sys_reset)
    begin
      config_one        <= wdsc_pkg::CONFIG_ONE_RESET;
      config_one_locked <= 1'b0;
    end
    else if (wr_config_one && !config_one_locked)
    begin
      config_one        <= hwdata[7:0];
      config_one_locked <= 1'b1;
    end
  end

  // Second configuration register; pin enable cleared by power-on only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_two        <= wdsc_pkg::CONFIG_TWO_RESET;
      config_two_locked <= 1'b0;
    end
    else if (sys_reset)
      config_two_locked <= 1'b0;
    else if (wr_config_two && !config_two_locked)
    begin
      config_two        <= hwdata[7:0];
      config_two_locked <= 1'b1;
    end
  end

  // Watchdog cause flag: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cause_watchdog <= 1'b0;
    else if (wd_expire)
      cause_watchdog <= 1'b1;
    else if (wr_cause && hwdata[wdsc_pkg::BIT_CAUSE_WD])
      cause_watchdog <= 1'b0;
  end

  // Power-on timer for the single prescaler clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_count <= 13'h0000;
      por_done  <= 1'b0;
    end
    else if (!por_done)
    begin
      por_count <= por_count + 13'h0001;
      if (por_count == 13'(wdsc_pkg::POR_CLEAR_CYCLES - 1))
        por_done <= 1'b1;
    end
  end

  // System prescaler
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prescaler <= '0;
    else if (sys_reset || stop_go || (state != wdsc_pkg::WDSC_RUN))
      prescaler <= '0;
    else if (!por_done && (por_count == 13'(wdsc_pkg::POR_CLEAR_CYCLES - 1)))
      prescaler <= '0;
    else if (wr_service)
      prescaler <= {{(PB-LS){1'b0}}, prescaler[LS-1:0] + LS'(1)};
    else
      prescaler <= prescaler + PB'(1);
  end

  // Watchdog counter on prescaler carry; no interrupt source here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_count <= '0;
    else if (sys_reset || wr_service || wd_disabled)
      wd_count <= '0;
    else if ((state == wdsc_pkg::WDSC_RUN) && !stop_go && (&prescaler))
      wd_count <= wd_count + 6'd1;
  end

  // Reset pulse timer and reset pin drive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pulse_count    <= 6'd0;
      watchdog_reset <= 1'b0;
      reset_pin_oe   <= 1'b0;
      reset_pin_out  <= 1'b0;
    end
    else
    begin
      reset_pin_out <= 1'b0;
      if (wd_expire)
      begin
        pulse_count    <= 6'(wdsc_pkg::RST_PULSE_CYCLES);
        watchdog_reset <= 1'b1;
        reset_pin_oe   <= config_two[wdsc_pkg::BIT_RST_PIN_EN];
      end
      else if (pulse_count > 6'd1)
        pulse_count <= pulse_count - 6'd1;
      else
      begin
        pulse_count    <= 6'd0;
        watchdog_reset <= 1'b0;
        reset_pin_oe   <= 1'b0;
      end
    end
  end

  // Stop entry, gating and recovery delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state        <= wdsc_pkg::WDSC_RUN;
      rec_count    <= 13'h0000;
      stop_illegal <= 1'b0;
      stop_mode    <= 1'b0;
    end
    else
    begin
      stop_illegal <= stop_request && (state == wdsc_pkg::WDSC_RUN)
                      && !cfg.stop_enable && !sys_reset;
      case (state)
        wdsc_pkg::WDSC_RUN:
        begin
          if (stop_go && !sys_reset)
          begin
            state     <= wdsc_pkg::WDSC_STOPPED;
            stop_mode <= 1'b1;
          end
        end
        wdsc_pkg::WDSC_STOPPED:
        begin
          if (lvd_reset)
          begin
            state     <= wdsc_pkg::WDSC_RECOVER;
            rec_count <= 13'(wdsc_pkg::REC_LONG_CYCLES - 1);
          end
          else if (wake_sync)
          begin
            state     <= wdsc_pkg::WDSC_RECOVER;
            rec_count <= cfg.short_stop_recovery
                         ? 13'(wdsc_pkg::REC_SHORT_CYCLES - 1)
                         : 13'(wdsc_pkg::REC_LONG_CYCLES - 1);
          end
        end
        wdsc_pkg::WDSC_RECOVER:
        begin
          if (rec_count == 13'h0000)
          begin
            state     <= wdsc_pkg::WDSC_RUN;
            stop_mode <= 1'b0;
          end
          else
            rec_count <= rec_count - 13'h0001;
        end
        default:
        begin
          state     <= wdsc_pkg::WDSC_RUN;
          stop_mode <= 1'b0;
        end
      endcase
    end
  end

  // Unused request fields and configuration bits
  logic unused_bits;
  assign unused_bits = ^{hsize, hwdata[31:8], config_one[6:4], config_one[2]};

endmodule : wdsc_top

// ---- tb/wdsc_assertions.sv ----
// Port checker for the watchdog block.
// Assumes it is bound onto wdsc_top, whose port names it shares.
module wdsc_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  reset_vector_low,
  input wire logic        stop_request,
  input wire logic        monitor_mode,
  input wire logic        break_active,
  input wire logic        break_watchdog_disable,
  input wire logic        stop_illegal,
  input wire logic        stop_mode,
  input wire logic        watchdog_reset,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe
);
  logic [5:0]  hi_cnt;
  logic [12:0] st_cnt;
  wire         svc_rd = hsel && htrans[1] && hready && !hwrite && haddr == 32'h0003FFFC;
  wire         brk_off = monitor_mode && break_active && break_watchdog_disable;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Length of the running reset pulse
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hi_cnt <= 6'h00;
    else
      hi_cnt <= watchdog_reset ? hi_cnt + 6'h01 : 6'h00;

  // Cycles spent in stop and recovery
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      st_cnt <= 13'h0000;
    else
      st_cnt <= stop_mode ? st_cnt + 13'h0001 : 13'h0000;

  pulse_len_a: assert property ($fell(watchdog_reset) |-> hi_cnt == 6'h20)
    else $error("reset pulse not 32 cycles");
  pulse_max_a: assert property (hi_cnt <= 6'h20)
    else $error("reset pulse too long");
  pin_drive_a: assert property (reset_pin_oe |-> watchdog_reset && !reset_pin_out)
    else $error("reset pin driven outside pulse");
  svc_read_a: assert property (svc_rd |=> hrdata[7:0] == $past(reset_vector_low))
    else $error("service read not vector byte");
  stop_cause_a: assert property ($rose(stop_mode) |-> $past(stop_request))
    else $error("stop entered without request");
  illegal_cause_a: assert property (stop_illegal |-> $past(stop_request) && !$rose(stop_mode))
    else $error("illegal pulse without request");
  stop_frozen_a: assert property (stop_mode && $past(stop_mode) |-> !$rose(watchdog_reset))
    else $error("expiry during stop");
  brk_quiet_a: assert property (brk_off && $past(brk_off) |-> !$rose(watchdog_reset))
    else $error("expiry during break");
  recov_min_a: assert property ($fell(stop_mode) |-> st_cnt > 13'h0020)
    else $error("stop recovery too short");

  cover property ($rose(watchdog_reset));
  cover property (stop_illegal);
  cover property ($fell(stop_mode));
endmodule : wdsc_checker

bind wdsc_top wdsc_checker u_wdsc_checker (.*);

// ---- tb/tb_top.sv ----
// Self-checking bench for the watchdog block.
// Assumes one AHB-Lite master and shortened timeouts.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LT = 600;
  localparam int ST = 200;
  localparam logic [31:0] A_CF1 = {14'h0, wdsc_pkg::IDX_CONFIG_ONE, 2'b00};
  localparam logic [31:0] A_CF2 = {14'h0, wdsc_pkg::IDX_CONFIG_TWO, 2'b00};
  localparam logic [31:0] A_RC  = {14'h0, wdsc_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [31:0] A_SVC = {14'h0, wdsc_pkg::IDX_SERVICE, 2'b00};
  localparam logic [31:0] DIS   = 32'h1 << wdsc_pkg::BIT_WD_DISABLE;
  localparam logic [31:0] SEN   = 32'h1 << wdsc_pkg::BIT_STOP_ENABLE;
  localparam logic [31:0] SRC   = 32'h1 << wdsc_pkg::BIT_SHORT_REC;
  localparam logic [31:0] RSL   = 32'h1 << wdsc_pkg::BIT_RATE_SELECT;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0]  vec = 8'hA5;
  logic        irst = 1'b0, sreq = 1'b0, swk = 1'b0, lvd = 1'b0;
  logic        mon = 1'b0, thv = 1'b0, brk = 1'b0, bwd = 1'b0;
  logic        hreadyout, hresp, ill, stp, wdr, rpo, rpoe;
  int          fail_count = 0, samples_checked = 0, rises = 0, ills = 0, n;

  wdsc_top #(.LONG_TIMEOUT(LT), .SHORT_TIMEOUT(ST)) u_wdsc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reset_vector_low(vec), .internal_reset(irst), .stop_request(sreq),
    .stop_wakeup(swk), .lvd_reset(lvd), .monitor_mode(mon), .test_high_voltage(thv),
    .break_active(brk), .break_watchdog_disable(bwd), .stop_illegal(ill),
    .stop_mode(stp), .watchdog_reset(wdr), .reset_pin_out(rpo), .reset_pin_oe(rpoe));

  // Clock and event counters
  always #4 hclk = ~hclk;
  always @(posedge wdr) rises++;
  always @(posedge ill) ills++;

  task stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single AHB-Lite transfer
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rd & m, e);
    check({hreadyout, hresp}, 2'b10);
  endtask : rdc

  task do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : do_reset

  task quiet(input int c);
    int r;
    r = rises;
    repeat (c) @(posedge hclk);
    check(rises - r, 0);
  endtask : quiet

  // Cycles to expiry, then pulse length and pin drive
  task expire(input int t);
    int m;
    n = 0;
    m = 0;
    while (wdr !== 1'b1 && n < 5000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check(n >= t - 16 && n <= t + 2, 1);
    check(rpoe, 1'b1);
    while (wdr === 1'b1 && m < 100)
    begin
      @(posedge hclk);
      #1;
      m++;
    end
    check(m, 32);
  endtask : expire

  task stop_pulse;
    @(posedge hclk);
    sreq <= 1'b1;
    @(posedge hclk);
    sreq <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
  endtask : stop_pulse

  // Wake up and time the recovery
  task wake(input logic l, input int lo, input int hi);
    @(posedge hclk);
    swk <= 1'b1;
    lvd <= l;
    n = 0;
    while (stp !== 1'b0 && n < 6000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check(n >= lo && n <= hi, 1);
    @(posedge hclk);
    swk <= 1'b0;
    lvd <= 1'b0;
  endtask : wake

  // Bench timeout
  initial
  begin
    repeat (40000) @(posedge hclk);
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    do_reset();
    rdc(A_CF1, 32'hFF, 32'h0);
    rdc(A_SVC, 32'hFF, 32'hA5);
    @(posedge hclk);
    vec <= 8'h3C;
    rdc(A_SVC, 32'hFF, 32'h3C);
    rdc(32'h100, 32'hFFFFFFFF, 32'h0);
    xfer(A_CF1, 1'b1, DIS);
    xfer(A_CF1, 1'b1, RSL);
    rdc(A_CF1, 32'hFF, DIS);
    quiet(1500);
    do_reset();
    xfer(A_CF2, 1'b1, 32'h1);
    xfer(A_SVC, 1'b1, 32'h5A);
    expire(LT);
    rdc(A_RC, 32'h1, 32'h1);
    xfer(A_RC, 1'b1, 32'h1);
    rdc(A_RC, 32'h1, 32'h0);
    rdc(A_CF1, 32'hFF, 32'h0);
    xfer(A_CF1, 1'b1, RSL);
    rdc(A_CF1, 32'hFF, RSL);
    xfer(A_SVC, 1'b1, 32'hFF);
    expire(ST);
    @(posedge hclk);
    irst <= 1'b1;
    @(posedge hclk);
    irst <= 1'b0;
    rdc(A_CF1, 32'hFF, 32'h0);
    rdc(A_CF2, 32'h1, 32'h1);
    do_reset();
    for (int i = 0; i < 6; i++)
    begin
      xfer(A_SVC, 1'b1, i * 37);
      quiet(450);
    end
    do_reset();
    stop_pulse();
    check(ills, 1);
    check(stp, 1'b0);
    xfer(A_CF1, 1'b1, SEN | SRC);
    stop_pulse();
    check(stp, 1'b1);
    quiet(1000);
    wake(1'b0, 32, 40);
    stop_pulse();
    wake(1'b1, 4096, 4104);
    do_reset();
    @(posedge hclk);
    mon <= 1'b1;
    thv <= 1'b1;
    quiet(1500);
    thv <= 1'b0;
    brk <= 1'b1;
    bwd <= 1'b1;
    quiet(1500);
    stop_test();
  end
endmodule : tb_top
